/* cbde_exec.sv */
// Execution logic for compare-skip-less, decimal adjust and decrement
// Assumes data memory answers reads combinationally within the Q4 phase
`timescale 1ns/1ps
module cbde_exec (
   input  wire logic        ref_clk,
   input  wire logic        rstn,
   input  wire logic        clk_en,
   input  wire logic [1:0]  q_phase,
   input  wire logic        instr_valid,
   input  wire logic [15:0] instr_word,
   input  wire logic        next_is_two_word,
   input  wire logic [7:0]  mem_rdata,
   input  wire logic        bank_wr,
   input  wire logic [3:0]  bank_wdata,
   output logic      [11:0] mem_addr,
   output logic             mem_we,
   output logic      [7:0]  mem_wdata,
   output logic      [7:0]  accumulator_register,
   output logic      [3:0]  bank_select_register,
   output logic             carry_flag,
   output logic             digit_carry_flag,
   output logic             negative_flag,
   output logic             overflow_flag,
   output logic             zero_flag,
   output logic             flush_fetch,
   output logic             nop_cycle
);
   cbde_pkg::cbde_state_t state_reg, state_next;
   logic [7:0] acc_reg, acc_next, wdat_reg, wdat_next;
   logic [3:0] bank_reg, bank_next;
   logic       we_reg, we_next;
   logic [11:0] addr_reg, addr_next;
   logic [4:0] flags_reg, flags_next; // C DC N OV Z
   logic       is_cmp, is_dec, is_daa, exec;
   logic [7:0] dec_val, daa_val;
   logic [3:0] lo_adj;
   logic [4:0] hi_sum;
   logic       lo_fix, hi_fix;
   logic [11:0] addr_comb;

   assign exec   = clk_en && instr_valid && state_reg == cbde_pkg::CBDE_EXEC;
   assign is_cmp = instr_word[15:12] == cbde_pkg::OPC_HI_CMP && instr_word[11:9] == cbde_pkg::OPC_CMP_LT;
   assign is_dec = instr_word[15:10] == cbde_pkg::OPC_DEC_HI;
   assign is_daa = instr_word == cbde_pkg::OPC_DAA;

   // Addressing: access bank splits low general registers and high special registers
   always_comb begin
      if (!instr_word[cbde_pkg::BIT_A]) begin
         if (instr_word[7:0] < cbde_pkg::ACCESS_SPLIT)
            addr_comb = {4'h0, instr_word[7:0]};
         else
            addr_comb = {cbde_pkg::ACCESS_HI_BANK, instr_word[7:0]};
      end else begin
         addr_comb = {bank_reg, instr_word[7:0]};
      end
   end

   // Decrement: add 0xFF so carry means no borrow
   logic [8:0] dec_full;
   logic [4:0] dec_low;
   assign dec_full = {1'b0, mem_rdata} + 9'h0FF;
   assign dec_low  = {1'b0, mem_rdata[3:0]} + 5'h0F;
   assign dec_val  = dec_full[7:0];

   // Decimal adjust
   assign lo_fix = acc_reg[3:0] > cbde_pkg::BCD_LIMIT || flags_reg[3];
   assign lo_adj = lo_fix ? acc_reg[3:0] + cbde_pkg::BCD_FIX : acc_reg[3:0];
   assign hi_sum = {1'b0, acc_reg[7:4]} + {4'h0, flags_reg[3]};
   assign hi_fix = hi_sum > {1'b0, cbde_pkg::BCD_LIMIT} || flags_reg[4];
   logic [4:0] hi_res;
   assign hi_res = hi_fix ? hi_sum + {1'b0, cbde_pkg::BCD_FIX} : hi_sum;
   assign daa_val = {hi_res[3:0], lo_adj};

   always_comb begin
      state_next = state_reg;
      acc_next   = acc_reg;
      bank_next  = bank_reg;
      flags_next = flags_reg;
      we_next    = clk_en ? 1'b0 : we_reg;
      wdat_next  = wdat_reg;
      addr_next  = addr_reg;
      if (clk_en) begin
         if (bank_wr)
            bank_next = bank_wdata;
         if (q_phase == cbde_pkg::PH_Q4) begin
            case (state_reg)
               cbde_pkg::CBDE_EXEC: begin
                  if (instr_valid && is_cmp && mem_rdata < acc_reg)
                     state_next = next_is_two_word ? cbde_pkg::CBDE_FLUSH2 : cbde_pkg::CBDE_FLUSH1;
                  else if (instr_valid && is_daa) begin
                     acc_next      = daa_val;
                     flags_next[4] = hi_res[4] | flags_reg[4];
                  end else if (instr_valid && is_dec) begin
                     flags_next = {dec_full[8], dec_low[4], dec_val[7],
                                   mem_rdata == 8'h80, dec_val == 8'h00};
                     if (!instr_word[cbde_pkg::BIT_D])
                        acc_next = dec_val;
                     else begin
                        we_next   = 1'b1;
                        wdat_next = dec_val;
                        addr_next = addr_comb;
                     end
                  end
               end
               cbde_pkg::CBDE_FLUSH2: state_next = cbde_pkg::CBDE_FLUSH1;
               cbde_pkg::CBDE_FLUSH1: state_next = cbde_pkg::CBDE_EXEC;
               default: state_next = cbde_pkg::CBDE_EXEC;
            endcase
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= cbde_pkg::CBDE_EXEC;
         acc_reg   <= cbde_pkg::ACC_RST;
         bank_reg  <= cbde_pkg::BANK_RST;
         flags_reg <= 5'h00;
         we_reg    <= 1'b0;
         wdat_reg  <= 8'h00;
         addr_reg  <= 12'h000;
      end else begin
         state_reg <= state_next;
         acc_reg   <= acc_next;
         bank_reg  <= bank_next;
         flags_reg <= flags_next;
         we_reg    <= we_next;
         wdat_reg  <= wdat_next;
         addr_reg  <= addr_next;
      end
   end

   // Read address is live so data arrives by Q4; write address is held for the write pulse
   assign mem_addr  = we_reg ? addr_reg : addr_comb;
   assign mem_we    = we_reg;
   assign mem_wdata = wdat_reg;
   assign accumulator_register = acc_reg;
   assign bank_select_register = bank_reg;
   assign {carry_flag, digit_carry_flag, negative_flag, overflow_flag, zero_flag} = flags_reg;
   assign nop_cycle   = state_reg != cbde_pkg::CBDE_EXEC;
   assign flush_fetch = exec && q_phase == cbde_pkg::PH_Q4 && is_cmp && mem_rdata < acc_reg;

   a_cmp_flags: assert property (@(posedge ref_clk) disable iff (!rstn)
      exec && q_phase == cbde_pkg::PH_Q4 && is_cmp |=> $stable(flags_reg))
      else $error("compare altered flags");
   sequence s_skip;
      exec && q_phase == cbde_pkg::PH_Q4 && is_cmp && mem_rdata < acc_reg && !next_is_two_word;
   endsequence
   a_skip_one: assert property (@(posedge ref_clk) disable iff (!rstn)
      s_skip |=> state_reg == cbde_pkg::CBDE_FLUSH1)
      else $error("short skip wrong");
   a_skip_two: assert property (@(posedge ref_clk) disable iff (!rstn)
      exec && q_phase == cbde_pkg::PH_Q4 && is_cmp && mem_rdata < acc_reg && next_is_two_word
      |=> state_reg == cbde_pkg::CBDE_FLUSH2)
      else $error("long skip wrong");
   a_no_skip: assert property (@(posedge ref_clk) disable iff (!rstn)
      exec && q_phase == cbde_pkg::PH_Q4 && is_cmp && mem_rdata >= acc_reg |=> !nop_cycle)
      else $error("spurious skip");
   a_access_lo: assert property (@(posedge ref_clk) disable iff (!rstn)
      !instr_word[cbde_pkg::BIT_A] && !instr_word[7] |-> addr_comb[11:8] == 4'h0)
      else $error("access bank wrong");
   a_banked: assert property (@(posedge ref_clk) disable iff (!rstn)
      instr_word[cbde_pkg::BIT_A] |-> addr_comb[11:8] == bank_reg)
      else $error("banked address wrong");
   a_dec_acc: assert property (@(posedge ref_clk) disable iff (!rstn)
      exec && q_phase == cbde_pkg::PH_Q4 && is_dec && !instr_word[cbde_pkg::BIT_D]
      |=> acc_reg == $past(mem_rdata) - 8'h01)
      else $error("decrement to accumulator wrong");
   a_dec_mem: assert property (@(posedge ref_clk) disable iff (!rstn)
      exec && q_phase == cbde_pkg::PH_Q4 && is_dec && instr_word[cbde_pkg::BIT_D]
      |=> mem_we && mem_wdata == $past(mem_rdata) - 8'h01)
      else $error("decrement write-back wrong");
   a_daa_flags: assert property (@(posedge ref_clk) disable iff (!rstn)
      exec && q_phase == cbde_pkg::PH_Q4 && is_daa |=> flags_reg[3:0] == $past(flags_reg[3:0]))
      else $error("adjust touched other flags");
   a_daa_low: assert property (@(posedge ref_clk) disable iff (!rstn)
      exec && q_phase == cbde_pkg::PH_Q4 && is_daa && acc_reg[3:0] <= 4'h9 && !flags_reg[3]
      |=> acc_reg[3:0] == $past(acc_reg[3:0]))
      else $error("low nibble changed");

   // Taken-instruction decodes shared by the checks below
   logic q4_take, take_cmp, take_skip, take_daa, take_dec;
   assign q4_take   = exec && q_phase == cbde_pkg::PH_Q4;
   assign take_cmp  = q4_take && is_cmp;
   assign take_skip = take_cmp && mem_rdata < acc_reg;
   assign take_daa  = q4_take && is_daa;
   assign take_dec  = q4_take && is_dec;

   // Idle lengths are counted in clocks, so they hold only while phases step once per clock
   sequence s_idle_one;
      nop_cycle [*4] ##1 !nop_cycle;
   endsequence
   sequence s_idle_two;
      nop_cycle [*8] ##1 !nop_cycle;
   endsequence

   // Skip and idle cycles
   a_skip_len_one: assert property (@(posedge ref_clk) disable iff (!rstn)
      take_skip && !next_is_two_word |=> s_idle_one)
      else $error("one-word skip length wrong");
   a_skip_len_two: assert property (@(posedge ref_clk) disable iff (!rstn)
      take_skip && next_is_two_word |=> s_idle_two)
      else $error("two-word skip length wrong");
   a_flush_only_skip: assert property (@(posedge ref_clk) disable iff (!rstn)
      flush_fetch |-> take_skip)
      else $error("flush without skip");
   a_skip_flushes: assert property (@(posedge ref_clk) disable iff (!rstn)
      take_skip |-> flush_fetch)
      else $error("skip without flush");
   a_idle_no_flush: assert property (@(posedge ref_clk) disable iff (!rstn)
      nop_cycle |-> !flush_fetch)
      else $error("flush during idle cycle");
   a_idle_acc: assert property (@(posedge ref_clk) disable iff (!rstn)
      nop_cycle |=> $stable(acc_reg))
      else $error("accumulator changed while idle");
   a_idle_flags: assert property (@(posedge ref_clk) disable iff (!rstn)
      nop_cycle |=> $stable(flags_reg))
      else $error("flags changed while idle");
   a_idle_write: assert property (@(posedge ref_clk) disable iff (!rstn)
      nop_cycle |=> !mem_we)
      else $error("memory written while idle");
   a_cmp_acc: assert property (@(posedge ref_clk) disable iff (!rstn)
      take_cmp |=> $stable(acc_reg))
      else $error("compare altered accumulator");
   a_cmp_write: assert property (@(posedge ref_clk) disable iff (!rstn)
      take_cmp |=> !mem_we)
      else $error("compare wrote memory");

   // Decrement
   a_dec_carry: assert property (@(posedge ref_clk) disable iff (!rstn)
      take_dec |=> carry_flag == ($past(mem_rdata) != 8'h00))
      else $error("decrement carry wrong");
   a_dec_digit: assert property (@(posedge ref_clk) disable iff (!rstn)
      take_dec |=> digit_carry_flag == ($past(mem_rdata[3:0]) != 4'h0))
      else $error("decrement digit carry wrong");
   a_dec_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
      take_dec |=> zero_flag == ($past(mem_rdata) == 8'h01))
      else $error("decrement zero wrong");
   a_dec_neg: assert property (@(posedge ref_clk) disable iff (!rstn)
      take_dec
      |=> negative_flag == ($past(mem_rdata) == 8'h00 || $past(mem_rdata) > 8'h80))
      else $error("decrement negative wrong");
   a_dec_ovf: assert property (@(posedge ref_clk) disable iff (!rstn)
      take_dec |=> overflow_flag == ($past(mem_rdata) == 8'h80))
      else $error("decrement overflow wrong");
   a_dec_mem_acc: assert property (@(posedge ref_clk) disable iff (!rstn)
      take_dec && instr_word[cbde_pkg::BIT_D] |=> $stable(acc_reg))
      else $error("write-back altered accumulator");
   a_dec_acc_nowr: assert property (@(posedge ref_clk) disable iff (!rstn)
      take_dec && !instr_word[cbde_pkg::BIT_D] |=> !mem_we)
      else $error("accumulator destination wrote memory");
   a_dec_waddr: assert property (@(posedge ref_clk) disable iff (!rstn)
      take_dec && instr_word[cbde_pkg::BIT_D] |=> mem_addr == $past(addr_comb))
      else $error("write-back address wrong");
   a_we_pulse: assert property (@(posedge ref_clk) disable iff (!rstn)
      mem_we && clk_en |=> !mem_we)
      else $error("write pulse too long");

   // Decimal adjust
   a_daa_lo_fix: assert property (@(posedge ref_clk) disable iff (!rstn)
      take_daa && (acc_reg[3:0] > 4'h9 || digit_carry_flag)
      |=> acc_reg[3:0] == $past(acc_reg[3:0]) + 4'h6)
      else $error("low nibble fix wrong");
   a_daa_hi_plain: assert property (@(posedge ref_clk) disable iff (!rstn)
      take_daa && !carry_flag && ({1'b0, acc_reg[7:4]} + {4'h0, digit_carry_flag}) <= 5'h09
      |=> acc_reg[7:4] == $past(acc_reg[7:4]) + {3'h0, $past(digit_carry_flag)})
      else $error("high nibble plain wrong");
   a_daa_hi_fix: assert property (@(posedge ref_clk) disable iff (!rstn)
      take_daa && carry_flag
      |=> acc_reg[7:4] == $past(acc_reg[7:4]) + 4'h6 + {3'h0, $past(digit_carry_flag)})
      else $error("high nibble fix wrong");
   a_daa_carry_keep: assert property (@(posedge ref_clk) disable iff (!rstn)
      take_daa && carry_flag |=> carry_flag)
      else $error("adjust cleared carry");
   a_daa_no_write: assert property (@(posedge ref_clk) disable iff (!rstn)
      take_daa |=> !mem_we)
      else $error("adjust wrote memory");

   // Addressing and bank select
   a_access_hi: assert property (@(posedge ref_clk) disable iff (!rstn)
      !instr_word[cbde_pkg::BIT_A] && instr_word[7]
      |-> addr_comb[11:8] == cbde_pkg::ACCESS_HI_BANK)
      else $error("upper access bank wrong");
   a_addr_field: assert property (@(posedge ref_clk) disable iff (!rstn)
      !mem_we |-> mem_addr[7:0] == instr_word[7:0])
      else $error("file field not on address");
   a_bank_load: assert property (@(posedge ref_clk) disable iff (!rstn)
      clk_en && bank_wr |=> bank_select_register == $past(bank_wdata))
      else $error("bank select load wrong");

   // Clock enable low must hold the accumulator, flags, skip state and bank select
   a_freeze_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
      !clk_en
      |=> $stable(acc_reg) && $stable(flags_reg) && $stable(state_reg) && $stable(bank_reg))
      else $error("state moved while frozen");
endmodule

/* cbde_pkg.sv */
// Package for the compare/decimal-adjust/decrement execution block
// Assumes a four-phase instruction cycle driven by the core sequencer
package cbde_pkg;
   localparam logic [3:0] OPC_HI_CMP   = 4'h6;   // Compare-skip-less upper nibble
   localparam logic [2:0] OPC_CMP_LT   = 3'h0;   // Bits 11:9 of compare-skip-less
   localparam logic [5:0] OPC_DEC_HI   = 6'h01;  // Bits 15:10 of decrement
   localparam logic [15:0] OPC_DAA     = 16'h0007;
   localparam int          BIT_A       = 8;
   localparam int          BIT_D       = 9;
   localparam logic [3:0]  BCD_LIMIT   = 4'h9;
   localparam logic [3:0]  BCD_FIX     = 4'h6;
   localparam logic [7:0]  ACCESS_SPLIT = 8'h80; // Access bank low half is bank 0
   localparam logic [3:0]  ACCESS_HI_BANK = 4'hF;
   localparam logic [7:0]  ACC_RST     = 8'h00;
   localparam logic [3:0]  BANK_RST    = 4'h0;
   localparam logic [1:0]  PH_Q1 = 2'h0;
   localparam logic [1:0]  PH_Q2 = 2'h1;
   localparam logic [1:0]  PH_Q3 = 2'h2;
   localparam logic [1:0]  PH_Q4 = 2'h3;
   typedef enum logic [1:0] {CBDE_EXEC, CBDE_FLUSH1, CBDE_FLUSH2} cbde_state_t;
endpackage

/* compare_bcd_decrement_exec_tb_top.sv */
// Random and corner-case bench for the compare, adjust and decrement block
// Assumes Q4 takes the instruction, results show next cycle, clk_en high except in the frozen section
`timescale 1ns/1ps
module compare_bcd_decrement_exec_tb_top;
   logic        ref_clk, rstn, clk_en, instr_valid, next_is_two_word, bank_wr, mem_we;
   logic        carry_flag, digit_carry_flag, negative_flag, overflow_flag, zero_flag, flush_fetch, nop_cycle;
   logic [1:0]  q_phase;
   logic [15:0] instr_word;
   logic [7:0]  mem_rdata, mem_wdata, accumulator_register, m_acc, wd_exp;
   logic [3:0]  bank_wdata, bank_select_register, m_bsr;
   logic [11:0] mem_addr, wa_exp;
   logic [31:0] k, j;
   logic        m_c, m_dc, m_n, m_ov, m_z, we_exp;
   int          err_count = 0, n_compared = 0, nop_left = 0, seed = 57323;
   wire  [4:0]  flags = {carry_flag, digit_carry_flag, negative_flag, overflow_flag, zero_flag};
   cbde_exec DUT (.ref_clk, .rstn, .clk_en, .q_phase, .instr_valid, .instr_word, .next_is_two_word, .mem_rdata,
      .bank_wr, .bank_wdata, .mem_addr, .mem_we, .mem_wdata, .accumulator_register, .bank_select_register,
      .carry_flag, .digit_carry_flag, .negative_flag, .overflow_flag, .zero_flag, .flush_fetch, .nop_cycle);
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Low access half maps to bank 0, upper half to the top bank
   function automatic logic [11:0] ea(input logic a, input logic [7:0] f);
      if (a) return {m_bsr, f};
      return (f < 8'h80) ? {4'h0, f} : {4'hF, f};
   endfunction
   task automatic issue(input logic [15:0] iw, input logic [7:0] rd, input logic two, input logic iv,
                        input logic ld, input logic [3:0] bv);
      logic [7:0] r;
      logic [4:0] h;
      logic [3:0] l;
      logic       ign, is_cmp, is_dec;
      ign = (nop_left != 0) || !iv || !clk_en;
      is_cmp = (iw[15:12] == cbde_pkg::OPC_HI_CMP) && (iw[11:9] == cbde_pkg::OPC_CMP_LT);
      is_dec = (iw[15:10] == cbde_pkg::OPC_DEC_HI);
      for (int p = 0; p < 4; p++) begin
         q_phase <= 2'(p);
         instr_word <= iw;
         instr_valid <= iv;
         mem_rdata <= rd;
         next_is_two_word <= two;
         bank_wr <= ld && (p == 0);
         bank_wdata <= bv;
         #1;
         if (p == 0) begin
            chk("acc", accumulator_register, m_acc);
            chk("flags", flags, {m_c, m_dc, m_n, m_ov, m_z});
            chk("we", mem_we, we_exp);
            if (we_exp) chk("wdata", mem_wdata, wd_exp);
            if (we_exp) chk("waddr", mem_addr, wa_exp);
         end
         if (p == 1 && ld) m_bsr = bv;
         if (p == 2) chk("bank", bank_select_register, m_bsr);
         if (p == 2 && !ign && (is_cmp || is_dec)) chk("addr", mem_addr, ea(iw[8], iw[7:0]));
         if (p == 3) chk("flush", flush_fetch, !ign && is_cmp && rd < m_acc);
         chk("nop", nop_cycle, nop_left != 0);
         if (nop_left != 0) nop_left--;
         @(posedge ref_clk);
      end
      we_exp = 1'b0;
      if (!ign && is_cmp && rd < m_acc) nop_left = two ? 8 : 4;
      if (!ign && iw == cbde_pkg::OPC_DAA) begin
         l = (m_acc[3:0] > 4'h9 || m_dc) ? m_acc[3:0] + 4'h6 : m_acc[3:0];
         h = {1'b0, m_acc[7:4]} + 5'(m_dc);
         if (h > 5'h09) m_c = 1'b1;
         if (m_c) h = h + 5'h06;
         m_acc = {h[3:0], l};
      end
      if (!ign && is_dec) begin
         r = rd - 8'h01;
         {m_c, m_dc, m_n, m_ov, m_z} = {rd != 8'h00, rd[3:0] != 4'h0, r[7], rd == 8'h80, r == 8'h00};
         if (iw[9]) {we_exp, wd_exp, wa_exp} = {1'b1, r, ea(iw[8], iw[7:0])};
         else m_acc = r;
      end
   endtask
   task automatic summarize;
      if (err_count == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   initial begin
      rstn = 1'b0;
      clk_en = 1'b1;
      {instr_valid, next_is_two_word, bank_wr, q_phase, instr_word, mem_rdata, bank_wdata} = '0;
      {m_acc, m_bsr, m_c, m_dc, m_n, m_ov, m_z, we_exp} = '0;
      repeat (4) @(posedge ref_clk);
      rstn <= 1'b1;
      // Borrow edge cases, adjust of FF, unsigned compare edges, work offered during idle cycles
      issue(16'h0512, 8'h00, 1'b0, 1'b1, 1'b0, 4'h0);
      issue(cbde_pkg::OPC_DAA, 8'h00, 1'b0, 1'b1, 1'b0, 4'h0);
      issue(16'h04F0, 8'h80, 1'b0, 1'b1, 1'b0, 4'h0);
      issue(16'h0710, 8'h01, 1'b0, 1'b1, 1'b1, 4'hA);
      issue(16'h0520, 8'h05, 1'b0, 1'b0, 1'b0, 4'h0);
      issue(16'h6130, 8'hFE, 1'b0, 1'b1, 1'b0, 4'h0);
      issue(16'h6031, 8'h7F, 1'b0, 1'b1, 1'b0, 4'h0);
      issue(16'h6032, 8'h7E, 1'b0, 1'b1, 1'b0, 4'h0);
      issue(16'h0533, 8'h44, 1'b0, 1'b1, 1'b0, 4'h0);
      issue(16'h6134, 8'h00, 1'b1, 1'b1, 1'b0, 4'h0);
      issue(16'h6135, 8'h00, 1'b0, 1'b1, 1'b0, 4'h0);
      issue(cbde_pkg::OPC_DAA, 8'h00, 1'b0, 1'b1, 1'b0, 4'h0);
      issue(16'h0536, 8'h1A, 1'b0, 1'b1, 1'b0, 4'h0);
      issue(cbde_pkg::OPC_DAA, 8'h00, 1'b0, 1'b1, 1'b0, 4'h0);
      // Frozen clock enable: a decrement and a compare must leave no trace
      instr_valid <= 1'b0;
      clk_en <= 1'b0;
      @(posedge ref_clk);
      issue(16'h0536, 8'h00, 1'b0, 1'b1, 1'b0, 4'h0);
      issue(16'h6130, 8'h00, 1'b0, 1'b1, 1'b0, 4'h0);
      instr_valid <= 1'b0;
      clk_en <= 1'b1;
      @(posedge ref_clk);
      for (int i = 0; i < 400; i++) begin
         k = $random(seed);
         j = $random(seed);
         issue(k[1] ? {6'h01, k[13:4]} : k[0] ? cbde_pkg::OPC_DAA : {4'h6, 3'h0, k[12:4]},
               j[7:0], j[12], j[15:13] != 3'h0, j[16], j[11:8]);
      end
      summarize();
   end
endmodule
